//--- rtl/spsm_top.sv
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "spsm_defines.svh"
// How it works
// - frame and baud settings go active only on a changed selector or reset
// - selector units digit picks port function; 3, 6, 7, 8 act as none
// - selector tens digit picks 8-bit or 9-bit frame
// - hundreds digit enables even parity, thousands digit picks stop bits
// - selector writes outside 1080..2199 are ignored; port 1 resets to 1192
// - baud codes 1..10 map to 300..187500 baud; port 0 resets to 10
// - process word count acts only in addressed mode, 0 to 16
// - received process words fill slots 0..15 in arrival order
// - each outgoing slot sends its own connector number, 0 to 399
// - parameter word setting 3..127 gives three words, addressed mode only
// - addressed mode answers only its own station address 0..30
// - addressed mode faults when no own telegram arrives within 1..32 s
// - peer modes fault when telegram gap exceeds 40..10000 ms
module spsm_top #(
	parameter int MS_CYCLES = `SPSM_CLK_HZ / `SPSM_MS_PER_S * `SPSM_TICK_MS
) (
	input  logic                 clk,
	input  logic                 rst_n,
	input  logic                 ce,
	input  logic [5:0]           reg_addr,
	input  logic [15:0]          reg_wdata,
	input  logic                 reg_wr,
	input  logic                 reg_rd,
	output logic [15:0]          reg_rdata,
	input  logic                 rx_word_valid,
	input  logic                 rx_word_first,
	input  logic [15:0]          rx_word,
	input  logic                 rx_tel_done,
	input  logic                 rx_tel_ok,
	input  logic [4:0]           rx_tel_addr,
	input  logic [3:0]           tx_word_index,
	output logic [8:0]           tx_connector,
	output spsm_pkg::spsm_fn_t   p0_fn,
	output logic                 p0_frame9,
	output logic                 p0_parity_en,
	output logic                 p0_two_stop,
	output logic [17:0]          p0_baud_div,
	output logic [4:0]           p0_pzd_count,
	output logic [1:0]           p0_pkw_count,
	output spsm_pkg::spsm_fn_t   p1_fn,
	output logic                 p1_frame9,
	output logic                 p1_parity_en,
	output logic                 p1_two_stop,
	output logic [4:0]           p1_pzd_count,
	output logic [1:0]           p1_pkw_count,
	output logic                 rx_slot_we,
	output logic [3:0]           rx_slot_index,
	output logic [15:0]          rx_slot_data,
	output logic                 tel_accept,
	output logic                 port0_telegram_fault,
	output logic                 peer_link_fault_a,
	output logic                 peer_link_fault_b,
	output logic                 irq
);
	localparam logic [17:0] DIV_TAB [16] = '{
		18'h0,
		18'(`SPSM_CLK_HZ / `SPSM_BAUD_R01),
		18'(`SPSM_CLK_HZ / `SPSM_BAUD_R02),
		18'(`SPSM_CLK_HZ / `SPSM_BAUD_R03),
		18'(`SPSM_CLK_HZ / `SPSM_BAUD_R04),
		18'(`SPSM_CLK_HZ / `SPSM_BAUD_R05),
		18'(`SPSM_CLK_HZ / `SPSM_BAUD_R06),
		18'(`SPSM_CLK_HZ / `SPSM_BAUD_R07),
		18'(`SPSM_CLK_HZ / `SPSM_BAUD_R08),
		18'(`SPSM_CLK_HZ / `SPSM_BAUD_R09),
		18'(`SPSM_CLK_HZ / `SPSM_BAUD_R10),
		18'h0, 18'h0, 18'h0, 18'h0, 18'h0
	};

	function automatic logic sel_ok(input logic [15:0] s);
		sel_ok = s >= `SPSM_PROTO_MIN && s <= `SPSM_PROTO_MAX
			&& (s[`SPSM_DIG_STOP] == `SPSM_STOP1 || s[`SPSM_DIG_STOP] == `SPSM_STOP2)
			&& s[`SPSM_DIG_PAR] <= `SPSM_PAR_ON
			&& (s[`SPSM_DIG_LEN] == `SPSM_LEN8 || s[`SPSM_DIG_LEN] == `SPSM_LEN9)
			&& s[`SPSM_DIG_FN] <= `SPSM_DIG_MAX;
	endfunction : sel_ok

	function automatic spsm_pkg::spsm_fn_t fn_dec(input logic [15:0] s);
		fn_dec = spsm_pkg::spsm_fn_none;
		if (s[`SPSM_DIG_FN] inside {spsm_pkg::spsm_fn_ext, spsm_pkg::spsm_fn_addr, spsm_pkg::spsm_fn_p2p2,
				spsm_pkg::spsm_fn_p2p4, spsm_pkg::spsm_fn_diag}) begin
			fn_dec = spsm_pkg::spsm_fn_t'(s[`SPSM_DIG_FN]);
		end
	endfunction : fn_dec

	function automatic logic [4:0] pzd_eff(input spsm_pkg::spsm_fn_t f, input logic [15:0] c);
		pzd_eff = (f == spsm_pkg::spsm_fn_addr) ? c[4:0] : 5'h0;
	endfunction : pzd_eff

	function automatic logic [1:0] pkw_eff(input spsm_pkg::spsm_fn_t f, input logic [15:0] c);
		pkw_eff = (f == spsm_pkg::spsm_fn_addr && c >= `SPSM_PKW_MIN) ? `SPSM_PKW_WORDS : 2'h0;
	endfunction : pkw_eff

	logic [15:0] p0_proto_q, p0_pzd_q, p0_pkw_q, p0_baud_q, p0_addr_q;
	logic [15:0] p0_fail_q, p0_peer_q, p1_proto_q, p1_pzd_q, p1_pkw_q;
	logic [15:0] p0_act_sel_q, p0_act_baud_q, p1_act_sel_q;
	logic [8:0]  slot_q [16];
	logic [2:0]  stat_q, mask_q, flt_q, exp_v, ev;
	logic [15:0] rdata_q, ms_cnt_q;
	logic        tick_q, tel_accept_q, we_q;
	logic [3:0]  idx_out_q;
	logic [15:0] data_out_q;
	logic [8:0]  conn_q;
	logic [4:0]  rx_idx_q, rx_use, rx_lim;
	logic        p0_p2p, tel_qual, peer_qual, exp_tel, exp_peer;
	logic        wr0;

	assign wr0 = ce && reg_wr;

	// configuration store; out-of-range writes leave the old value
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			p0_proto_q <= `SPSM_RST_P0_PROTO;
			p0_pzd_q   <= 16'h0;
			p0_pkw_q   <= 16'h0;
			p0_baud_q  <= `SPSM_RST_P0_BAUD;
			p0_addr_q  <= 16'h0;
			p0_fail_q  <= `SPSM_RST_P0_FAIL;
			p0_peer_q  <= `SPSM_RST_P0_PEER;
			p1_proto_q <= `SPSM_RST_P1_PROTO;
			p1_pzd_q   <= `SPSM_RST_P1_PZD;
			p1_pkw_q   <= `SPSM_RST_P1_PKW;
			mask_q     <= 3'h0;
		end else if (wr0) begin
			case (reg_addr)
				`SPSM_A_P0_PROTO: if (sel_ok(reg_wdata)) p0_proto_q <= reg_wdata;
				`SPSM_A_P0_PZD:   if (reg_wdata <= `SPSM_PZD_MAX) p0_pzd_q <= reg_wdata;
				`SPSM_A_P0_PKW:   if (reg_wdata <= `SPSM_PKW_MAX) p0_pkw_q <= reg_wdata;
				`SPSM_A_P0_BAUD: begin
					if (reg_wdata >= `SPSM_BAUD_MIN && reg_wdata <= `SPSM_BAUD_MAX) p0_baud_q <= reg_wdata;
				end
				`SPSM_A_P0_ADDR:  if (reg_wdata <= `SPSM_ADDR_MAX) p0_addr_q <= reg_wdata;
				`SPSM_A_P0_FAIL:  if (reg_wdata <= `SPSM_FAIL_MAX) p0_fail_q <= reg_wdata;
				`SPSM_A_P0_PEER: begin
					if (reg_wdata >= `SPSM_PEER_MIN && reg_wdata <= `SPSM_PEER_MAX) p0_peer_q <= reg_wdata;
				end
				`SPSM_A_P1_PROTO: if (sel_ok(reg_wdata)) p1_proto_q <= reg_wdata;
				`SPSM_A_P1_PZD:   if (reg_wdata <= `SPSM_PZD_MAX) p1_pzd_q <= reg_wdata;
				`SPSM_A_P1_PKW:   if (reg_wdata <= `SPSM_PKW_MAX) p1_pkw_q <= reg_wdata;
				`SPSM_A_MASK:     mask_q <= reg_wdata[2:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 16; i++) begin
				slot_q[i] <= 9'h0;
			end
		end else if (wr0 && reg_addr[`SPSM_SLOT_FLD] == `SPSM_SLOT_PAGE && reg_wdata <= `SPSM_CONN_MAX) begin
			slot_q[reg_addr[3:0]] <= reg_wdata[8:0];
		end
	end

	// the baud code is copied only here, so an edit alone never disturbs a live link
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			p0_act_sel_q  <= `SPSM_RST_P0_PROTO;
			p0_act_baud_q <= `SPSM_RST_P0_BAUD;
			p1_act_sel_q  <= `SPSM_RST_P1_PROTO;
		end else if (wr0) begin
			if (reg_addr == `SPSM_A_P0_PROTO && sel_ok(reg_wdata) && reg_wdata != p0_proto_q) begin
				p0_act_sel_q  <= reg_wdata;
				p0_act_baud_q <= p0_baud_q;
			end
			if (reg_addr == `SPSM_A_P1_PROTO && sel_ok(reg_wdata) && reg_wdata != p1_proto_q) begin
				p1_act_sel_q <= reg_wdata;
			end
		end
	end

	assign p0_fn        = fn_dec(p0_act_sel_q);
	assign p0_frame9    = p0_act_sel_q[`SPSM_DIG_LEN] == `SPSM_LEN9;
	assign p0_parity_en = p0_act_sel_q[`SPSM_DIG_PAR] == `SPSM_PAR_ON;
	assign p0_two_stop  = p0_act_sel_q[`SPSM_DIG_STOP] == `SPSM_STOP2;
	assign p0_baud_div  = DIV_TAB[p0_act_baud_q[3:0]];
	assign p1_fn        = fn_dec(p1_act_sel_q);
	assign p1_frame9    = p1_act_sel_q[`SPSM_DIG_LEN] == `SPSM_LEN9;
	assign p1_parity_en = p1_act_sel_q[`SPSM_DIG_PAR] == `SPSM_PAR_ON;
	assign p1_two_stop  = p1_act_sel_q[`SPSM_DIG_STOP] == `SPSM_STOP2;
	assign p0_pzd_count = pzd_eff(p0_fn, p0_pzd_q);
	assign p0_pkw_count = pkw_eff(p0_fn, p0_pkw_q);
	assign p1_pzd_count = pzd_eff(p1_fn, p1_pzd_q);
	assign p1_pkw_count = pkw_eff(p1_fn, p1_pkw_q);
	assign p0_p2p       = p0_fn == spsm_pkg::spsm_fn_p2p2 || p0_fn == spsm_pkg::spsm_fn_p2p4;

	// outgoing slot lookup, one cycle behind the index
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			conn_q <= 9'h0;
		end else if (ce) begin
			conn_q <= (p0_fn == spsm_pkg::spsm_fn_addr || p0_p2p) ? slot_q[tx_word_index] : 9'h0;
		end
	end
	assign tx_connector = conn_q;

	// received word delivery; words past the active count are dropped
	assign rx_lim = (p0_fn == spsm_pkg::spsm_fn_addr) ? p0_pzd_count : (p0_p2p ? `SPSM_SLOTS : 5'h0);
	assign rx_use = rx_word_first ? 5'h0 : rx_idx_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_idx_q   <= 5'h0;
			we_q       <= 1'b0;
			idx_out_q  <= 4'h0;
			data_out_q <= 16'h0;
		end else if (ce) begin
			we_q <= 1'b0;
			if (rx_word_valid) begin
				if (rx_use < rx_lim) begin
					we_q       <= 1'b1;
					idx_out_q  <= rx_use[3:0];
					data_out_q <= rx_word;
				end
				if (rx_use != `SPSM_SLOTS) begin
					rx_idx_q <= rx_use + 5'h1;
				end
			end
		end
	end
	assign rx_slot_we    = we_q;
	assign rx_slot_index = idx_out_q;
	assign rx_slot_data  = data_out_q;

	// millisecond tick shared by both supervisors
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ms_cnt_q <= 16'h0;
			tick_q   <= 1'b0;
		end else if (ce) begin
			tick_q <= ms_cnt_q == 16'(MS_CYCLES - 1);
			ms_cnt_q <= (ms_cnt_q == 16'(MS_CYCLES - 1)) ? 16'h0 : ms_cnt_q + 16'h1;
		end
	end

	assign tel_qual  = rx_tel_done && rx_tel_ok && p0_fn == spsm_pkg::spsm_fn_addr
		&& rx_tel_addr == p0_addr_q[4:0];
	assign peer_qual = rx_tel_done && rx_tel_ok && p0_p2p;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tel_accept_q <= 1'b0;
		end else if (ce) begin
			tel_accept_q <= tel_qual;
		end
	end
	assign tel_accept = tel_accept_q;

	spsm_sup_timer u_tel_timer (
		.clk     (clk),
		.rst_n   (rst_n),
		.ce      (ce),
		.tick    (tick_q),
		.run     (p0_fn == spsm_pkg::spsm_fn_addr && p0_fail_q != 16'h0),
		.restart (tel_qual),
		.limit   (15'(p0_fail_q * `SPSM_MS_PER_S)),
		.expired (exp_tel)
	);

	spsm_sup_timer u_peer_timer (
		.clk     (clk),
		.rst_n   (rst_n),
		.ce      (ce),
		.tick    (tick_q),
		.run     (p0_p2p),
		.restart (peer_qual),
		.limit   (p0_peer_q[14:0]),
		.expired (exp_peer)
	);

	// fault levels and their rising-edge events; a new event beats a clearing read
	assign exp_v = {exp_peer && p0_fn == spsm_pkg::spsm_fn_p2p4, exp_peer && p0_fn == spsm_pkg::spsm_fn_p2p2, exp_tel};
	assign ev    = exp_v & ~flt_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flt_q  <= 3'h0;
			stat_q <= 3'h0;
		end else if (ce) begin
			flt_q  <= exp_v;
			stat_q <= ((reg_rd && reg_addr == `SPSM_A_STATUS) ? 3'h0 : stat_q) | ev;
		end
	end
	assign port0_telegram_fault = flt_q[`SPSM_ST_TEL];
	assign peer_link_fault_a    = flt_q[`SPSM_ST_PEER_A];
	assign peer_link_fault_b    = flt_q[`SPSM_ST_PEER_B];
	assign irq                  = |(stat_q & mask_q);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 16'h0;
		end else if (ce) begin
			rdata_q <= 16'h0;
			if (reg_rd) begin
				case (reg_addr)
					`SPSM_A_P0_PROTO: rdata_q <= p0_proto_q;
					`SPSM_A_P0_PZD:   rdata_q <= p0_pzd_q;
					`SPSM_A_P0_PKW:   rdata_q <= p0_pkw_q;
					`SPSM_A_P0_BAUD:  rdata_q <= p0_baud_q;
					`SPSM_A_P0_ADDR:  rdata_q <= p0_addr_q;
					`SPSM_A_P0_FAIL:  rdata_q <= p0_fail_q;
					`SPSM_A_P0_PEER:  rdata_q <= p0_peer_q;
					`SPSM_A_P1_PROTO: rdata_q <= p1_proto_q;
					`SPSM_A_P1_PZD:   rdata_q <= p1_pzd_q;
					`SPSM_A_P1_PKW:   rdata_q <= p1_pkw_q;
					`SPSM_A_STATUS:   rdata_q <= {13'h0, stat_q};
					`SPSM_A_MASK:     rdata_q <= {13'h0, mask_q};
					`SPSM_A_ACT0:     rdata_q <= p0_act_sel_q;
					`SPSM_A_ACT1:     rdata_q <= p1_act_sel_q;
					default: begin
						if (reg_addr[`SPSM_SLOT_FLD] == `SPSM_SLOT_PAGE) rdata_q <= {7'h0, slot_q[reg_addr[3:0]]};
					end
				endcase
			end
		end
	end
	assign reg_rdata = rdata_q;

	a_baud_defer: assert property (@(posedge clk) disable iff (!rst_n)
		wr0 && reg_addr == `SPSM_A_P0_BAUD |=> $stable(p0_act_baud_q) && $stable(p0_baud_div))
		else $error("baud edit changed the active baud");
	a_sel_reject: assert property (@(posedge clk) disable iff (!rst_n)
		wr0 && reg_addr == `SPSM_A_P0_PROTO && !sel_ok(reg_wdata) |=> $stable(p0_proto_q) && $stable(p0_act_sel_q))
		else $error("invalid selector was taken");
	a_fn_apply: assert property (@(posedge clk) disable iff (!rst_n)
		wr0 && reg_addr == `SPSM_A_P0_PROTO && sel_ok(reg_wdata) && reg_wdata != p0_proto_q
		|=> p0_fn == fn_dec($past(reg_wdata)) && p0_act_baud_q == $past(p0_baud_q))
		else $error("selector change did not apply");
	a_frame_len: assert property (@(posedge clk) disable iff (!rst_n)
		wr0 && reg_addr == `SPSM_A_P0_PROTO && sel_ok(reg_wdata) && reg_wdata != p0_proto_q
		&& reg_wdata[`SPSM_DIG_LEN] == `SPSM_LEN9 |=> p0_frame9)
		else $error("9-bit frame not selected");
	a_par_stop: assert property (@(posedge clk) disable iff (!rst_n)
		wr0 && reg_addr == `SPSM_A_P0_PROTO && sel_ok(reg_wdata) && reg_wdata != p0_proto_q
		&& reg_wdata[`SPSM_DIG_PAR] == `SPSM_PAR_ON && reg_wdata[`SPSM_DIG_STOP] == `SPSM_STOP2
		|=> p0_parity_en && p0_two_stop)
		else $error("parity or stop bits wrong");
	a_baud_map: assert property (@(posedge clk) disable iff (!rst_n)
		p0_act_baud_q == `SPSM_BAUD_MAX |-> p0_baud_div == 18'(`SPSM_CLK_HZ / `SPSM_BAUD_R10))
		else $error("baud divisor mismatch");
	a_pzd_gate: assert property (@(posedge clk) disable iff (!rst_n)
		p0_fn != spsm_pkg::spsm_fn_addr |-> p0_pzd_count == 5'h0 && p0_pkw_count == 2'h0)
		else $error("word counts active outside addressed mode");
	a_pkw_three: assert property (@(posedge clk) disable iff (!rst_n)
		p0_fn == spsm_pkg::spsm_fn_addr && p0_pkw_q >= `SPSM_PKW_MIN |-> p0_pkw_count == `SPSM_PKW_WORDS)
		else $error("parameter word count not three");
	a_slot_first: assert property (@(posedge clk) disable iff (!rst_n)
		ce && rx_word_valid && rx_word_first && rx_lim != 5'h0
		|=> rx_slot_we && rx_slot_index == 4'h0 && rx_slot_data == $past(rx_word))
		else $error("first word not in first slot");
	a_addr_only: assert property (@(posedge clk) disable iff (!rst_n)
		tel_accept |-> $past(p0_addr_q) == {11'h0, $past(rx_tel_addr)})
		else $error("accepted a foreign station address");
	a_tel_fault: assert property (@(posedge clk) disable iff (!rst_n)
		ce && exp_tel && !flt_q[`SPSM_ST_TEL] |=> stat_q[`SPSM_ST_TEL] && port0_telegram_fault)
		else $error("telegram timeout not flagged");
	a_peer_fault: assert property (@(posedge clk) disable iff (!rst_n)
		ce && exp_peer && p0_fn == spsm_pkg::spsm_fn_p2p2 && !flt_q[`SPSM_ST_PEER_A]
		|=> stat_q[`SPSM_ST_PEER_A] && peer_link_fault_a)
		else $error("peer timeout not flagged");
endmodule : spsm_top

//--- rtl/spsm_defines.svh
`ifndef SPSM_DEFINES_SVH
`define SPSM_DEFINES_SVH

`define SPSM_CLK_HZ      40000000
`define SPSM_TICK_MS     1
`define SPSM_MS_PER_S    1000

`define SPSM_A_P0_PROTO  6'h00
`define SPSM_A_P0_PZD    6'h01
`define SPSM_A_P0_PKW    6'h02
`define SPSM_A_P0_BAUD   6'h03
`define SPSM_A_P0_ADDR   6'h04
`define SPSM_A_P0_FAIL   6'h05
`define SPSM_A_P0_PEER   6'h06
`define SPSM_A_P1_PROTO  6'h07
`define SPSM_A_P1_PZD    6'h08
`define SPSM_A_P1_PKW    6'h09
`define SPSM_A_STATUS    6'h0B
`define SPSM_A_MASK      6'h0C
`define SPSM_A_ACT0      6'h0D
`define SPSM_A_ACT1      6'h0E
`define SPSM_SLOT_FLD    5:4
`define SPSM_SLOT_PAGE   2'h1

`define SPSM_DIG_FN      3:0
`define SPSM_DIG_LEN     7:4
`define SPSM_DIG_PAR     11:8
`define SPSM_DIG_STOP    15:12
`define SPSM_DIG_MAX     4'h9
`define SPSM_LEN8        4'h8
`define SPSM_LEN9        4'h9
`define SPSM_PAR_ON      4'h1
`define SPSM_STOP1       4'h1
`define SPSM_STOP2       4'h2

`define SPSM_RST_P0_PROTO 16'h1180
`define SPSM_RST_P0_BAUD  16'h000A
`define SPSM_RST_P0_FAIL  16'h0001
`define SPSM_RST_P0_PEER  16'h0028
`define SPSM_RST_P1_PROTO 16'h1192
`define SPSM_RST_P1_PZD   16'h0003
`define SPSM_RST_P1_PKW   16'h0003

`define SPSM_PROTO_MIN   16'h1080
`define SPSM_PROTO_MAX   16'h2199
`define SPSM_PZD_MAX     16'h0010
`define SPSM_PKW_MIN     16'h0003
`define SPSM_PKW_MAX     16'h007F
`define SPSM_PKW_WORDS   2'h3
`define SPSM_BAUD_MIN    16'h0001
`define SPSM_BAUD_MAX    16'h000A
`define SPSM_ADDR_MAX    16'h001E
`define SPSM_FAIL_MAX    16'h0020
`define SPSM_PEER_MIN    16'h0028
`define SPSM_PEER_MAX    16'h2710
`define SPSM_CONN_MAX    16'h018F
`define SPSM_SLOTS       5'h10

`define SPSM_BAUD_R01    300
`define SPSM_BAUD_R02    600
`define SPSM_BAUD_R03    1200
`define SPSM_BAUD_R04    2400
`define SPSM_BAUD_R05    4800
`define SPSM_BAUD_R06    9600
`define SPSM_BAUD_R07    19200
`define SPSM_BAUD_R08    38400
`define SPSM_BAUD_R09    93750
`define SPSM_BAUD_R10    187500

`define SPSM_ST_TEL      0
`define SPSM_ST_PEER_A   1
`define SPSM_ST_PEER_B   2

`endif

//--- rtl/spsm_pkg.sv
package spsm_pkg;
	typedef enum logic [3:0] {
		spsm_fn_none = 4'h0,
		spsm_fn_ext  = 4'h1,
		spsm_fn_addr = 4'h2,
		spsm_fn_p2p2 = 4'h4,
		spsm_fn_p2p4 = 4'h5,
		spsm_fn_diag = 4'h9
	} spsm_fn_t;
endpackage : spsm_pkg

//--- rtl/spsm_sup_timer.sv
`timescale 1ns/1ps
module spsm_sup_timer (
	input  logic        clk,
	input  logic        rst_n,
	input  logic        ce,
	input  logic        tick,
	input  logic        run,
	input  logic        restart,
	input  logic [14:0] limit,
	output logic        expired
);
	logic [14:0] cnt_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 15'h0;
		end else if (ce) begin
			if (!run || restart) begin
				cnt_q <= 15'h0;
			end else if (tick && !expired) begin
				cnt_q <= cnt_q + 15'h1;
			end
		end
	end

	// saturates at the limit, so the fault level holds until a telegram restarts it, run drops or the limit is raised
	assign expired = run && (cnt_q >= limit);

	a_restart_clears: assert property (@(posedge clk) disable iff (!rst_n)
		ce && run && restart && limit != 15'h0 ##1 $stable(limit) && run |-> !expired)
		else $error("timer still expired after restart");
endmodule : spsm_sup_timer

//--- verif/spsm_link_station.sv
`timescale 1ns/1ps
// far-side station on port 0; released valid and first lines go low, word, ok and address lines show the inverse of their last value
module spsm_link_station (
	input  logic        clk,
	output logic        rx_word_valid,
	output logic        rx_word_first,
	output logic [15:0] rx_word,
	output logic        rx_tel_done,
	output logic        rx_tel_ok,
	output logic [4:0]  rx_tel_addr
);
	initial begin
		rx_word_valid = 1'b0;
		rx_word_first = 1'b0;
		rx_word       = 16'h5A5A;
		rx_tel_done   = 1'b0;
		rx_tel_ok     = 1'b0;
		rx_tel_addr   = 5'h0A;
	end

	// one telegram: nwords back-to-back words, then the end-of-telegram strobe
	task automatic send(input logic [4:0] addr, input int nwords, input logic ok);
		for (int i = 0; i < nwords; i++) begin
			@(posedge clk);
			rx_word_valid <= 1'b1;
			rx_word_first <= (i == 0);
			rx_word       <= 16'hA000 + 16'(i);
		end
		@(posedge clk);
		rx_word_valid <= 1'b0;
		rx_word_first <= 1'b0;
		rx_word       <= ~rx_word;
		rx_tel_done   <= 1'b1;
		rx_tel_ok     <= ok;
		rx_tel_addr   <= addr;
		@(posedge clk);
		rx_tel_done   <= 1'b0;
		rx_tel_ok     <= ~ok;
		rx_tel_addr   <= ~addr;
	endtask : send
endmodule : spsm_link_station

//--- verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic               clk, rst_n, ce, reg_wr, reg_rd, p0_frame9, p0_parity_en, p0_two_stop;
	logic               rx_word_valid, rx_word_first, rx_tel_done, rx_tel_ok, p1_frame9, p1_parity_en;
	logic               p1_two_stop, rx_slot_we, tel_accept, port0_telegram_fault, peer_link_fault_a;
	logic               peer_link_fault_b, irq;
	logic [5:0]         reg_addr;
	logic [15:0]        reg_wdata, reg_rdata, rx_word, rx_slot_data;
	logic [4:0]         rx_tel_addr, p0_pzd_count, p1_pzd_count;
	logic [3:0]         tx_word_index, rx_slot_index;
	logic [8:0]         tx_connector;
	logic [17:0]        p0_baud_div;
	logic [1:0]         p0_pkw_count, p1_pkw_count;
	spsm_pkg::spsm_fn_t p0_fn, p1_fn;
	int                 err_total, comparisons, accepts, i;
	logic [19:0]        slots[$];
	logic [5:0]         ra[11] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0D, 6'h0A};
	logic [15:0]        rv[11] = '{16'h0, 16'h0, 16'h000A, 16'h0, 16'h0001, 16'h0028, 16'h1192, 16'h0003,
	                               16'h0003, 16'h1180, 16'h0};
	logic [3:0]         fc[7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h9};
	logic [3:0]         fe[7] = '{4'h0, 4'h1, 4'h2, 4'h0, 4'h4, 4'h5, 4'h9};

	spsm_top #(.MS_CYCLES(4)) i_dut (.clk, .rst_n, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.rx_word_valid, .rx_word_first, .rx_word, .rx_tel_done, .rx_tel_ok, .rx_tel_addr, .tx_word_index,
		.tx_connector, .p0_fn, .p0_frame9, .p0_parity_en, .p0_two_stop, .p0_baud_div, .p0_pzd_count,
		.p0_pkw_count, .p1_fn, .p1_frame9, .p1_parity_en, .p1_two_stop, .p1_pzd_count, .p1_pkw_count,
		.rx_slot_we, .rx_slot_index, .rx_slot_data, .tel_accept, .port0_telegram_fault, .peer_link_fault_a,
		.peer_link_fault_b, .irq);
	spsm_link_station i_link (.clk, .rx_word_valid, .rx_word_first, .rx_word, .rx_tel_done, .rx_tel_ok,
		.rx_tel_addr);

	always #12.5 clk = ~clk;

	always @(posedge clk) begin
		if (rx_slot_we === 1'b1) begin
			slots.push_back({rx_slot_index, rx_slot_data});
		end
		if (tel_accept === 1'b1) begin
			accepts++;
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s: expected %0h, seen %0h", what, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
	endtask : wr

	task automatic rd_chk(input logic [5:0] a, input logic [15:0] exp, input string what);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		@(negedge clk);
		chk(what, {16'h0, exp}, {16'h0, reg_rdata});
	endtask : rd_chk

	// lets an applied setting reach the decoded outputs
	task automatic settle;
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask : settle

	task automatic wrap_up;
		$display("comparisons %0d, mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : wrap_up

	// longest wait is the 1 s telegram timeout, about 4000 cycles
	initial begin
		#(25 * 20000);
		err_total++;
		wrap_up;
	end

	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		ce = 1'b1;
		reg_addr = 6'h00;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		tx_word_index = 4'h0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		for (i = 0; i < 11; i++) rd_chk(ra[i], rv[i], "reset register");
		chk("reset baud divider", 32'd213, 32'(p0_baud_div));
		chk("p1 decode", {4'h2, 3'h6}, {p1_fn, p1_frame9, p1_parity_en, p1_two_stop});
		chk("p1 counts", {5'h03, 2'h3}, {p1_pzd_count, p1_pkw_count});
		$display("test reset_values done");

		wr(6'h03, 16'h0005);
		settle;
		chk("baud held", 32'd213, 32'(p0_baud_div));
		for (i = 0; i < 7; i++) begin
			wr(6'h00, 16'h1080 | 16'(fc[i]));
			settle;
			chk("function", 32'(fe[i]), 32'(p0_fn));
		end
		chk("baud applied", 32'd8333, 32'(p0_baud_div));
		wr(6'h00, 16'h2199);
		settle;
		chk("frame format", 32'h7, {29'h0, p0_frame9, p0_parity_en, p0_two_stop});
		wr(6'h00, 16'h2200);
		wr(6'h00, 16'h1079);
		rd_chk(6'h0D, 16'h2199, "active selector");
		wr(6'h03, 16'h0001);
		wr(6'h00, 16'h2199);
		settle;
		chk("baud not reapplied", 32'd8333, 32'(p0_baud_div));
		$display("test selector done");

		wr(6'h04, 16'h0005);
		wr(6'h05, 16'h0001);
		wr(6'h01, 16'h0010);
		wr(6'h02, 16'h0002);
		wr(6'h1F, 16'h018F);
		wr(6'h10, 16'h0190);
		wr(6'h0C, 16'h0001);
		wr(6'h00, 16'h1082);
		settle;
		chk("frame 8 no parity", 32'h0, {29'h0, p0_frame9, p0_parity_en, p0_two_stop});
		chk("baud 300", 32'd133333, 32'(p0_baud_div));
		chk("counts", {5'h10, 2'h0}, {p0_pzd_count, p0_pkw_count});
		wr(6'h02, 16'h007F);
		wr(6'h01, 16'h0003);
		settle;
		chk("counts", {5'h3, 2'h3}, {p0_pzd_count, p0_pkw_count});
		@(posedge clk);
		tx_word_index <= 4'hF;
		settle;
		chk("slot 15 connector", 32'd399, 32'(tx_connector));
		@(posedge clk);
		tx_word_index <= 4'h0;
		settle;
		chk("slot 0 connector", 32'd0, 32'(tx_connector));
		i_link.send(5'h05, 4, 1'b1);
		i_link.send(5'h06, 0, 1'b1);
		i_link.send(5'h05, 0, 1'b0);
		settle;
		chk("accepted telegrams", 32'd1, 32'(accepts));
		chk("slot writes", 32'd3, 32'(slots.size()));
		for (i = 0; i < 3; i++) chk("slot write", 32'(i) << 16 | 32'hA000 + 32'(i), 32'(slots[i]));
		i_link.send(5'h05, 0, 1'b1);
		repeat (3900) @(posedge clk);
		chk("early fault", 32'd0, 32'(port0_telegram_fault));
		for (i = 0; i < 300 && port0_telegram_fault !== 1'b1; i++) @(posedge clk);
		settle;
		chk("telegram fault", 32'd3, {30'h0, port0_telegram_fault, irq});
		rd_chk(6'h0B, 16'h0001, "status");
		settle;
		chk("irq after clear", 32'd0, 32'(irq));
		$display("test addressed done");

		wr(6'h03, 16'h000A);
		wr(6'h06, 16'h0028);
		wr(6'h0C, 16'h0006);
		wr(6'h00, 16'h1084);
		wr(6'h07, 16'h1085);
		settle;
		chk("mode change", {4'h4, 4'h5, 1'b0}, {p0_fn, p1_fn, port0_telegram_fault});
		chk("baud 187500", 32'd213, 32'(p0_baud_div));
		rd_chk(6'h0E, 16'h1085, "p1 active selector");
		slots.delete();
		i_link.send(5'h09, 17, 1'b1);
		repeat (150) @(posedge clk);
		chk("slot writes", 32'd16, 32'(slots.size()));
		chk("early peer fault", 32'd0, 32'(peer_link_fault_a));
		for (i = 0; i < 40 && peer_link_fault_a !== 1'b1; i++) @(posedge clk);
		settle;
		chk("peer fault", 32'd3, {30'h0, peer_link_fault_a, irq});
		wr(6'h0C, 16'h0000);
		settle;
		chk("masked irq", 32'd0, 32'(irq));
		rd_chk(6'h0B, 16'h0002, "status");
		// four-wire peer mode reports on its own fault line
		wr(6'h00, 16'h1085);
		i_link.send(5'h09, 0, 1'b1);
		repeat (150) @(posedge clk);
		chk("early peer fault b", 32'd0, 32'(peer_link_fault_b));
		for (i = 0; i < 40 && peer_link_fault_b !== 1'b1; i++) @(posedge clk);
		settle;
		chk("peer fault b", 32'h1, {30'h0, peer_link_fault_a, peer_link_fault_b});
		rd_chk(6'h0B, 16'h0004, "status");
		$display("test peer done");
		wrap_up;
	end
endmodule : tb_top
